// ### pkg/out40_pkg.sv
package out40_pkg;

  // Host word and group geometry
  localparam int unsigned WORD_W       = 16;
  localparam int unsigned GROUP_W      = 8;
  localparam int unsigned GROUP_CNT    = 5;
  localparam int unsigned DATA_W       = 40;
  localparam int unsigned NIB_W        = 4;
  localparam int unsigned ADDR_W       = 3;
  localparam int unsigned CODE_W       = 4;

  // Digit positions inside a host word
  localparam int unsigned LOW_DIGIT_LSB  = 0;
  localparam int unsigned HIGH_DIGIT_LSB = 8;
  localparam int unsigned ALT_DIGIT_LSB  = 4;

  // Command port addresses (writes)
  localparam logic [ADDR_W-1:0] ADDR_OUTPUT_WORD = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_CLEAR_CTL   = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_SET_CTL     = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_CLEAR_FLAG  = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_PRINT_START = 3'h4;
  // Status address (reads)
  localparam logic [ADDR_W-1:0] ADDR_STATUS      = 3'h0;

  // Status word bit positions
  localparam int unsigned ST_FLAG_BIT    = 0;
  localparam int unsigned ST_CTL_BIT     = 1;
  localparam int unsigned ST_TIMEOUT_BIT = 3;
  localparam int unsigned ST_NEG_BIT     = 5;

  // Start codes
  localparam logic [CODE_W-1:0] CODE_LAST_GROUP = 4'h4;
  localparam logic [CODE_W-1:0] CODE_NO_INPUT   = 4'h5;
  localparam logic [CODE_W-1:0] CODE_CTL_BIT    = 4'h7;
  localparam logic [CODE_W-1:0] CODE_CLEAR_ALL  = 4'h8;
  localparam logic [CODE_W-1:0] CODE_SET_ALL    = 4'hF;
  localparam logic [CODE_W-1:0] CODE_RESET      = 4'h5;

  // Timing
  localparam longint unsigned CLK_PERIOD_PS   = 5000;
  localparam longint unsigned PRINT_PULSE_US  = 50;
  localparam longint unsigned TIMEOUT_MS      = 300;
  localparam longint unsigned PRINT_PULSE_CYC = (PRINT_PULSE_US * 1000000) / CLK_PERIOD_PS;
  localparam longint unsigned TIMEOUT_CYC     = (TIMEOUT_MS * 1000000000) / CLK_PERIOD_PS;
  localparam int unsigned     TIMER_W         = 27;

  // Host command sequencing mode
  typedef enum logic [1:0] {
    MODE_PRESET = 2'b01,
    MODE_DATA   = 2'b10
  } mode_e;

endpackage : out40_pkg

// ### hdl/forty_bit_output_register.sv
//
// Contract
// R1 - Forty bits in five byte groups, driven
// R2 - Upper digit bits 11-8, lower 3-0
// R3 - Build option: upper digit from bits 7-4
// R4 - Extra control output bit beyond forty
// R5 - Timeout status bit 3 after 300 ms
// R6 - Status bit 5: negative hold-off not restored
// R7 - Host reads status bits by input
// R8 - Preset counter picks word count, groups
// R9 - Codes 0-4 accept five to one words
// R10 - Code 5 no data; code 7 sets control
// R11 - Code 10 clears, 17 sets all on clear-control
// R12 - Power-on forces forty outputs to zero
// R13 - Clear-control presets; next word loads code
// R14 - After code load, mode leaves preset
// R15 - Later words present digits, decode address
// R16 - Strobe end latches group, increments counter
// R17 - Skipped groups keep previous contents
// R18 - Host issues set-control with clear-flag
// R19 - Set-control starts print, enables interrupt
// R20 - Clear-flag resets flag buffer and flag
// R21 - Print command one 50 us pulse
// R22 - Peripheral takes data, returns hold-off
// R23 - Hold-off return sets flag, interrupt
// R24 - Control bit decoded from counter state
// R25 - Words past last group ignored
`timescale 1ns/1ps
`default_nettype none

module forty_bit_output_register
  import out40_pkg::*;
#(
  parameter bit              UPPER_FROM_BITS_7_4 = 1'b0,
  parameter bit              TIMEOUT_ENABLE      = 1'b1,
  parameter longint unsigned PRINT_CYCLES        = out40_pkg::PRINT_PULSE_CYC,
  parameter longint unsigned TIMEOUT_CYCLES      = out40_pkg::TIMEOUT_CYC
) (
  input  wire  logic                                i_sys_clk,
  input  wire  logic                                i_srst,
  input  wire  logic [out40_pkg::ADDR_W-1:0]        i_addr,
  input  wire  logic [out40_pkg::WORD_W-1:0]        i_wdata,
  input  wire  logic                                i_wr,
  input  wire  logic                                i_rd,
  output logic       [out40_pkg::WORD_W-1:0]        o_rdata,
  input  wire  logic                                i_pos_holdoff,
  input  wire  logic                                i_neg_holdoff,
  output logic       [out40_pkg::DATA_W-1:0]        o_data_bits,
  output logic                                      o_control_bit,
  output logic                                      o_print_command,
  output logic                                      o_flag,
  output logic                                      o_irq_request
);
  import out40_pkg::*;

  // Refuse timing values the counters cannot hold
  if (PRINT_CYCLES < 1 || PRINT_CYCLES >= (64'h1 << TIMER_W)) begin : g_bad_print
    $error("print pulse length out of range");
  end
  if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES >= (64'h1 << TIMER_W)) begin : g_bad_timeout
    $error("timeout length out of range");
  end

  localparam logic [TIMER_W-1:0] PRINT_LAST   = TIMER_W'(PRINT_CYCLES - 1);
  localparam logic [TIMER_W-1:0] TIMEOUT_LAST = TIMER_W'(TIMEOUT_CYCLES - 1);

  // Decoded host commands
  logic                    io_output_strobe;
  logic [WORD_W-1:0]       io_output_data_lines;
  logic                    clear_control_command;
  logic                    set_control_command;
  logic                    clear_flag_command;
  logic                    output_word_command;

  // Sequencing state
  mode_e                   mode_q;
  logic [CODE_W-1:0]       cnt_q;
  logic [CODE_W-1:0]       cnt_d;
  logic [GROUP_W-1:0]      group_q [GROUP_CNT];
  logic [GROUP_W-1:0]      digit_pair;
  logic [GROUP_CNT-1:0]    group_sel;
  logic                    data_accept;

  // Peripheral handshake
  logic                    pos_meta_q;
  logic                    pos_sync_q;
  logic                    pos_prev_q;
  logic                    neg_meta_q;
  logic                    neg_sync_q;
  logic                    neg_ref_q;
  logic                    holdoff_return;
  logic                    ctl_en_q;
  logic                    flag_buf_q;
  logic                    flag_q;
  logic                    print_q;
  logic [TIMER_W-1:0]      print_cnt_q;
  logic                    waiting_q;
  logic [TIMER_W-1:0]      wait_cnt_q;
  logic                    timeout_q;
  logic                    neg_status_q;
  logic [WORD_W-1:0]       rdata_q;

  // Host backplane decode; combined command raises both parts
  assign output_word_command   = i_wr && (i_addr == ADDR_OUTPUT_WORD);
  assign io_output_strobe      = output_word_command;
  assign io_output_data_lines  = i_wdata;
  assign clear_control_command = i_wr && (i_addr == ADDR_CLEAR_CTL);
  assign set_control_command   = i_wr && ((i_addr == ADDR_SET_CTL) ||
                                          (i_addr == ADDR_PRINT_START));    // [R18]
  assign clear_flag_command    = i_wr && ((i_addr == ADDR_CLEAR_FLAG) ||
                                          (i_addr == ADDR_PRINT_START));

  // Digit selection; upper digit source is a build-time option
  always_comb begin
    digit_pair[NIB_W-1:0] = io_output_data_lines[LOW_DIGIT_LSB +: NIB_W];       // [R2]
    if (UPPER_FROM_BITS_7_4) begin
      digit_pair[GROUP_W-1:NIB_W] = io_output_data_lines[ALT_DIGIT_LSB +: NIB_W];  // [R3]
    end else begin
      digit_pair[GROUP_W-1:NIB_W] = io_output_data_lines[HIGH_DIGIT_LSB +: NIB_W]; // [R2]
    end
  end

  // Data words only land while the counter points at a group
  assign data_accept = io_output_strobe && (mode_q == MODE_DATA) &&
                       (cnt_q <= CODE_LAST_GROUP);                              // [R25]

  // Next counter value: preset load or advance after each accepted word
  always_comb begin
    cnt_d = cnt_q;
    if (io_output_strobe && (mode_q == MODE_PRESET)) begin
      cnt_d = io_output_data_lines[CODE_W-1:0];                                 // [R13]
    end else if (data_accept) begin
      cnt_d = cnt_q + 4'h1;                                                     // [R16]
    end
  end

  // Mode flip-flop: clear-control arms preset, code load leaves it
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      mode_q <= MODE_DATA;
    end else if (clear_control_command) begin
      mode_q <= MODE_PRESET;                                                    // [R13]
    end else if (io_output_strobe && (mode_q == MODE_PRESET)) begin
      mode_q <= MODE_DATA;                                                      // [R14]
    end
  end

  // Address counter; reset value accepts no data until preset
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      cnt_q <= CODE_RESET;
    end else begin
      cnt_q <= cnt_d;                                                           // [R8]
    end
  end

  // Control bit is a decode of the counter, so a reload to any code but 7 or 15 clears it
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_control_bit <= 1'b0;
    end else begin
      o_control_bit <= (cnt_d == CODE_CTL_BIT) || (cnt_d == CODE_SET_ALL);      // [R4] [R24] [R10]
    end
  end

  // One-hot decode of the current address, strobed by the data word
  always_comb begin
    group_sel = '0;
    for (int g = 0; g < GROUP_CNT; g++) begin
      group_sel[g] = data_accept && (cnt_q == CODE_W'(g));                     // [R15] [R9]
    end
  end

  // Five storage groups; group 0 holds the most significant digits
  for (genvar g = 0; g < GROUP_CNT; g++) begin : g_group
    always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
        group_q[g] <= '0;                                                       // [R12]
      end else if (clear_control_command && (cnt_q == CODE_CLEAR_ALL)) begin
        group_q[g] <= '0;                                                       // [R11]
      end else if (clear_control_command && (cnt_q == CODE_SET_ALL)) begin
        group_q[g] <= '1;                                                       // [R11]
      end else if (group_sel[g]) begin
        group_q[g] <= digit_pair;                                               // [R16]
      end
      // Unselected groups simply hold                                          // [R17]
    end
    assign o_data_bits[DATA_W-1-g*GROUP_W -: GROUP_W] = group_q[g];            // [R1]
  end

  // Two-stage synchronisers for the peripheral hold-off lines
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      pos_meta_q <= 1'b0;
      pos_sync_q <= 1'b0;
      neg_meta_q <= 1'b0;
      neg_sync_q <= 1'b0;
    end else begin
      pos_meta_q <= i_pos_holdoff;
      pos_sync_q <= pos_meta_q;
      neg_meta_q <= i_neg_holdoff;
      neg_sync_q <= neg_meta_q;
    end
  end

  // Previous synchronised level for return detection
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      pos_prev_q <= 1'b0;
    end else begin
      pos_prev_q <= pos_sync_q;
    end
  end

  // Hold-off returning to ground is the peripheral's completion
  assign holdoff_return = pos_prev_q && !pos_sync_q;                            // [R22]

  // Control flip-flop gates the interrupt request
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      ctl_en_q <= 1'b0;
    end else if (set_control_command) begin
      ctl_en_q <= 1'b1;                                                         // [R19]
    end else if (clear_control_command) begin
      ctl_en_q <= 1'b0;
    end
  end

  // Print pulse: fixed length, retriggered by a fresh set-control
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      print_q     <= 1'b0;
      print_cnt_q <= '0;
    end else if (set_control_command) begin
      print_q     <= 1'b1;                                                      // [R19]
      print_cnt_q <= '0;
    end else if (print_q) begin
      if (print_cnt_q == PRINT_LAST) begin
        print_q <= 1'b0;                                                        // [R21]
      end else begin
        print_cnt_q <= print_cnt_q + TIMER_W'(1);
      end
    end
  end

  assign o_print_command = print_q;

  // Override timer; a lost hold-off must not lock the host up
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      waiting_q  <= 1'b0;
      wait_cnt_q <= '0;
      timeout_q  <= 1'b0;
    end else if (set_control_command) begin
      waiting_q  <= 1'b1;
      wait_cnt_q <= '0;
      timeout_q  <= 1'b0;
    end else if (waiting_q) begin
      if (holdoff_return) begin
        waiting_q <= 1'b0;
      end else if (wait_cnt_q == TIMEOUT_LAST) begin
        waiting_q <= 1'b0;
        timeout_q <= TIMEOUT_ENABLE;                                            // [R5]
      end else begin
        wait_cnt_q <= wait_cnt_q + TIMER_W'(1);
      end
    end
  end

  // Negative hold-off level remembered at the print command
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      neg_ref_q    <= 1'b0;
      neg_status_q <= 1'b0;
    end else if (set_control_command) begin
      neg_ref_q    <= neg_sync_q;
      neg_status_q <= 1'b0;
    end else if (holdoff_return && (neg_sync_q != neg_ref_q)) begin
      neg_status_q <= 1'b1;                                                     // [R6]
    end
  end

  // Flag buffer then flag; a new event beats a same-cycle clear
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      flag_buf_q <= 1'b0;
    end else if (holdoff_return || (timeout_q == 1'b0 && waiting_q &&
                 wait_cnt_q == TIMEOUT_LAST && TIMEOUT_ENABLE)) begin
      flag_buf_q <= 1'b1;                                                       // [R23]
    end else if (clear_flag_command) begin
      flag_buf_q <= 1'b0;                                                       // [R20]
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      flag_q <= 1'b0;
    end else if (flag_buf_q && !clear_flag_command) begin
      flag_q <= 1'b1;                                                           // [R23]
    end else if (clear_flag_command) begin
      flag_q <= flag_buf_q && holdoff_return;                                   // [R20]
    end
  end

  assign o_flag = flag_q;

  // Interrupt request only while control is set
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_irq_request <= 1'b0;
    end else begin
      o_irq_request <= flag_q && ctl_en_q && !clear_flag_command;               // [R23]
    end
  end

  // Status read; data stand for the single cycle after the strobe
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= '0;
      if (i_rd && (i_addr == ADDR_STATUS)) begin
        rdata_q[ST_FLAG_BIT]    <= flag_q;
        rdata_q[ST_CTL_BIT]     <= ctl_en_q;
        rdata_q[ST_TIMEOUT_BIT] <= timeout_q;                                   // [R7] [R5]
        rdata_q[ST_NEG_BIT]     <= neg_status_q;                                // [R7] [R6]
      end
    end
  end

  assign o_rdata = rdata_q;

endmodule // forty_bit_output_register

`default_nettype wire

// ### dv/out40_checker_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module out40_checker
  import out40_pkg::*;
#(
  parameter longint unsigned PRINT_CYCLES        = out40_pkg::PRINT_PULSE_CYC,
  parameter bit              UPPER_FROM_BITS_7_4 = 1'b0
) (
  input wire logic                          i_sys_clk,
  input wire logic                          i_srst,
  input wire logic [out40_pkg::ADDR_W-1:0]  i_addr,
  input wire logic [out40_pkg::WORD_W-1:0]  i_wdata,
  input wire logic                          i_wr,
  input wire logic                          i_rd,
  input wire logic [out40_pkg::WORD_W-1:0]  o_rdata,
  input wire logic                          i_pos_holdoff,
  input wire logic                          i_neg_holdoff,
  input wire logic [out40_pkg::DATA_W-1:0]  o_data_bits,
  input wire logic                          o_control_bit,
  input wire logic                          o_print_command,
  input wire logic                          o_flag,
  input wire logic                          o_irq_request
);
  logic               load_req;
  logic               word_req;
  logic [GROUP_W-1:0] word_digits;
  longint unsigned    hi_cnt_q;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);

  // Only these writes may move latches or the counter
  assign load_req = i_wr && (i_addr == ADDR_OUTPUT_WORD || i_addr == ADDR_CLEAR_CTL);

  // Digit pair the latches should take from an output word
  assign word_req    = i_wr && (i_addr == ADDR_OUTPUT_WORD);
  assign word_digits = {UPPER_FROM_BITS_7_4 ? i_wdata[ALT_DIGIT_LSB +: NIB_W]
                                            : i_wdata[HIGH_DIGIT_LSB +: NIB_W],
                        i_wdata[LOW_DIGIT_LSB +: NIB_W]};

  // Print pulse length so far, zero while low
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || !o_print_command) begin
      hi_cnt_q <= '0;
    end else begin
      hi_cnt_q <= hi_cnt_q + 1;
    end
  end

  sequence s_print_req;
    i_wr && i_addr == ADDR_PRINT_START;
  endsequence
  sequence s_holdoff_return;
    $fell(i_pos_holdoff);
  endsequence

  property p_reset_zero;
    disable iff (1'h0) i_srst |=> o_data_bits == '0 && !o_print_command && !o_flag;
  endproperty
  property p_print_len;
    !$past(i_srst) && $fell(o_print_command) |-> hi_cnt_q == PRINT_CYCLES;
  endproperty
  property p_print_start;
    s_print_req |=> o_print_command;
  endproperty
  property p_flag_clear;
    s_print_req |=> !o_flag;
  endproperty
  property p_flag_set;
    s_holdoff_return |-> ##[1:8] o_flag;
  endproperty
  property p_irq_needs_flag;
    o_irq_request |-> $past(o_flag);
  endproperty
  property p_data_hold;
    !$stable(o_data_bits) |-> $past(load_req) || $past(i_srst);
  endproperty
  property p_ctl_hold;
    !$stable(o_control_bit) |-> $past(load_req) || $past(i_srst);
  endproperty
  property p_rdata_idle;
    !i_rd |=> o_rdata == '0;
  endproperty
  property p_word_lands;
    !$stable(o_data_bits) && $past(word_req) |->
      o_data_bits[39:32] == $past(word_digits) || o_data_bits[31:24] == $past(word_digits) ||
      o_data_bits[23:16] == $past(word_digits) || o_data_bits[15:8] == $past(word_digits) ||
      o_data_bits[7:0] == $past(word_digits);
  endproperty

  a_reset_zero:     assert property (p_reset_zero) else $error("outputs not clear after reset");
  a_print_len:      assert property (p_print_len) else $error("print pulse length wrong");
  a_print_start:    assert property (p_print_start) else $error("print pulse missing");
  a_flag_clear:     assert property (p_flag_clear) else $error("flag not cleared");
  a_flag_set:       assert property (p_flag_set) else $error("flag not set on return");
  a_irq_needs_flag: assert property (p_irq_needs_flag) else $error("interrupt without flag");
  a_data_hold:      assert property (p_data_hold) else $error("data moved without write");
  a_ctl_hold:       assert property (p_ctl_hold) else $error("control bit moved alone");
  a_rdata_idle:     assert property (p_rdata_idle) else $error("read data not idle");
  a_word_lands:     assert property (p_word_lands) else $error("data word landed wrong");
endmodule // out40_checker

bind forty_bit_output_register out40_checker #(.PRINT_CYCLES(PRINT_CYCLES),
  .UPPER_FROM_BITS_7_4(UPPER_FROM_BITS_7_4)) out40_checker_inst (
  .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_pos_holdoff(i_pos_holdoff),
  .i_neg_holdoff(i_neg_holdoff), .o_data_bits(o_data_bits), .o_control_bit(o_control_bit),
  .o_print_command(o_print_command), .o_flag(o_flag), .o_irq_request(o_irq_request)
);

`default_nettype wire

// ### dv/printer_model.sv
`timescale 1ns/1ps
`default_nettype none

module printer_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_print_command,
  input  wire logic [1:0] i_mode,   // 0 normal, 1 never returns, 2 paper low
  input  wire logic [7:0] i_delay,
  output logic            o_pos_holdoff,
  output logic            o_neg_holdoff
);
  logic       prev_q;
  logic       busy_q;
  logic [7:0] cnt_q;

  // Both hold-off lines idle in their open state
  initial begin
    prev_q = 1'h0;
    busy_q = 1'h0;
    cnt_q = 8'h00;
    o_pos_holdoff = 1'h0;
    o_neg_holdoff = 1'h0;
  end

  // Hold off on a print pulse, return after the chosen delay
  always @(posedge i_sys_clk) begin
    prev_q <= i_print_command;
    if (i_print_command && !prev_q) begin
      busy_q <= 1'h1;
      cnt_q <= i_delay;
      o_pos_holdoff <= 1'h1;
      o_neg_holdoff <= 1'h1;
    end else if (busy_q && cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end else if (busy_q && i_mode != 2'h1) begin // Stuck mode models a dead printer
      busy_q <= 1'h0;
      o_pos_holdoff <= 1'h0;
      o_neg_holdoff <= (i_mode == 2'h2);
    end
  end
endmodule // printer_model

`default_nettype wire

// ### dv/tb_forty_bit_output_register.sv
`timescale 1ns/1ps
`default_nettype none

module tb_forty_bit_output_register;
  import out40_pkg::*;
  logic              i_sys_clk = 1'h0;
  logic              i_srst = 1'h1;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [WORD_W-1:0] i_wdata = '0;
  logic              i_wr = 1'h0;
  logic              i_rd = 1'h0;
  logic [WORD_W-1:0] o_rdata, rv;
  logic              i_pos_holdoff, i_neg_holdoff;
  logic [DATA_W-1:0] o_data_bits, exp_bits;
  logic              o_control_bit, o_print_command, o_flag, o_irq_request;
  logic [1:0]        mode = 2'h0;
  logic [7:0]        delay = 8'h02;
  int                bad_count = 0;
  int                total_checks = 0;
  int                n;

  forty_bit_output_register #(.PRINT_CYCLES(5), .TIMEOUT_CYCLES(50))
    forty_bit_output_register_inst (
    .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pos_holdoff(i_pos_holdoff),
    .i_neg_holdoff(i_neg_holdoff), .o_data_bits(o_data_bits), .o_control_bit(o_control_bit),
    .o_print_command(o_print_command), .o_flag(o_flag), .o_irq_request(o_irq_request));

  printer_model printer_model_inst (.i_sys_clk(i_sys_clk), .i_print_command(o_print_command),
    .i_mode(mode), .i_delay(delay), .o_pos_holdoff(i_pos_holdoff),
    .o_neg_holdoff(i_neg_holdoff));

  // 200 MHz clock
  always #2.5 i_sys_clk = ~i_sys_clk;

  task chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task results();
    if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Strobes stay up until the next task's edge, so back-to-back is gapless
  task wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'h1;
    i_rd <= 1'h0;
    i_addr <= a;
    i_wdata <= d;
  endtask

  task rd(input logic [2:0] a);
    @(posedge i_sys_clk);
    i_rd <= 1'h1;
    i_wr <= 1'h0;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'h0;
    #1 rv = o_rdata;
  endtask

  task idle(input int k);
    repeat (k) begin
      @(posedge i_sys_clk);
      i_wr <= 1'h0;
      i_rd <= 1'h0;
    end
    #1;
  endtask

  task preset(input logic [3:0] c);
    wr(ADDR_CLEAR_CTL, 16'h0000);
    wr(ADDR_OUTPUT_WORD, {12'h000, c});
  endtask

  // Bounded wait; running out ends the run
  task wait_flag(input int lim);
    n = 0;
    while (o_flag !== 1'h1 && n < lim) begin
      idle(1);
      n++;
    end
    if (n >= lim) begin
      chk("flag wait", o_flag, 1);
      results();
    end
  endtask

  task t_load();
    preset(4'h0);
    for (int w = 0; w < 5; w++) wr(ADDR_OUTPUT_WORD, {4'hF, 4'(w + 1), 4'hF, 4'(9 - w)});
    idle(1);
    chk("full load", o_data_bits, 40'h1928374655);
    exp_bits = 40'h1928374655;
    for (int c = 0; c < 5; c++) begin
      preset(4'(c));
      wr(ADDR_OUTPUT_WORD, {4'h0, 4'(c), 4'h0, 4'(c)});
      idle(1);
      exp_bits[39 - 8 * c -: 8] = {4'(c), 4'(c)};
      chk("single group", o_data_bits, exp_bits);
    end
    preset(4'h3);
    wr(ADDR_OUTPUT_WORD, 16'h0A0B);
    wr(ADDR_OUTPUT_WORD, 16'h0C0D);
    wr(ADDR_OUTPUT_WORD, 16'h0E0E);
    idle(1);
    chk("overrun ignored", o_data_bits, 40'h001122ABCD);
  endtask

  task t_codes();
    preset(4'h5);
    wr(ADDR_OUTPUT_WORD, 16'h0101);
    preset(4'h7);
    idle(1);
    chk("code 7 data", o_data_bits, 40'h001122ABCD);
    chk("code 7 ctl", o_control_bit, 1);
    preset(4'h4);
    wr(ADDR_OUTPUT_WORD, 16'h0202);
    idle(1);
    chk("ctl dropped", o_control_bit, 0);
    chk("group 4", o_data_bits, 40'h001122AB22);
    preset(4'hF);
    wr(ADDR_CLEAR_CTL, 16'h0000);
    idle(1);
    chk("set all", o_data_bits, 40'hFFFFFFFFFF);
    chk("set all ctl", o_control_bit, 1);
    preset(4'h8);
    wr(ADDR_CLEAR_CTL, 16'h0000);
    idle(1);
    chk("clear all", o_data_bits, 40'h0000000000);
  endtask

  task t_print();
    wr(ADDR_PRINT_START, 16'h0000);
    n = 0;
    repeat (12) begin
      idle(1);
      if (o_print_command === 1'h1) n++;
    end
    chk("print length", n, 5);
    wait_flag(100);
    idle(3);
    chk("irq", o_irq_request, 1);
    rd(ADDR_STATUS);
    chk("status ok", rv, 16'h0003);
    rd(3'h5);
    chk("unmapped read", rv, 16'h0000);
    wr(ADDR_CLEAR_FLAG, 16'h0000);
    idle(3);
    chk("flag cleared", {o_flag, o_irq_request}, 0);
  endtask

  task t_faults();
    mode = 2'h2;
    delay = 8'h28;
    wr(ADDR_PRINT_START, 16'h0000);
    wait_flag(200);
    rd(ADDR_STATUS);
    chk("paper low", rv & 16'h0028, 16'h0020);
    mode = 2'h1;
    delay = 8'h02;
    wr(ADDR_PRINT_START, 16'h0000);
    idle(2);
    chk("flag at print start", o_flag, 0);
    wait_flag(200);
    rd(ADDR_STATUS);
    chk("timeout", rv & 16'h0009, 16'h0009);
    mode = 2'h0;
    idle(10);
  endtask

  // Reset, then each scenario in turn
  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_srst <= 1'h0;
    #1;
    chk("reset data", o_data_bits, 40'h0);
    chk("reset ctl", {o_control_bit, o_flag, o_irq_request, o_print_command}, 0);
    t_load();
    t_codes();
    t_print();
    t_faults();
    results();
  end
endmodule // tb_forty_bit_output_register

`default_nettype wire
